// File: flash_accel_defines.svh
// register offsets, field positions, reset values and timing counts
// assumes inclusion by bare name from the controller and its package users
`ifndef FLASH_ACCEL_DEFINES_SVH
`define FLASH_ACCEL_DEFINES_SVH

`define REG_CTRL        6'h00
`define REG_PROT        6'h04
`define REG_LOCK        6'h08
`define REG_PGM_ADDR    6'h0C
`define REG_PGM_LO      6'h10
`define REG_PGM_HI      6'h14
`define REG_STATUS      6'h18
`define REG_ECC_CNT     6'h1C
`define REG_ERASE_SEL   6'h20

`define CTRL_PFE_BIT    0
`define CTRL_BUFE_BIT   1
`define CTRL_DLY_LSB    2
`define CTRL_DLY_W      5
`define CTRL_SHADOW_BIT 7
`define CTRL_PGM_BIT    8
`define CTRL_ERS_BIT    9
`define CTRL_SUSP_BIT   10

`define CTRL_RESET      32'h0000_0003
`define PROT_RESET      32'h0000_FFFF
`define LOCK_RESET      32'hFFFF_FFFF

`define ARRAY_WAIT      2'h2
`define PGM_CYCLES      8'h10
`define ERS_CYCLES      8'h40

`endif

// File: flash_accel_pkg.sv
// types shared by the flash read accelerator
// assumes the defines header for numeric constants
package flash_accel_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DELAY,
    ST_ARRAY,
    ST_REG,
    ST_RESP
  } rd_state_type;

  typedef enum logic [1:0] {
    OP_IDLE,
    OP_PGM,
    OP_ERS,
    OP_SUSP
  } op_state_type;
endpackage : flash_accel_pkg

// File: flash_array_model.sv
// array macro model: 128-bit line reads with a fixed settle time
// assumes one line request outstanding; ecc flags are steered by the bench
`timescale 1ns/100ps
module flash_array_model (
  input  wire logic         clk_i,
  input  wire logic         rd_i,
  input  wire logic [16:0]  line_i,
  input  wire logic         sbe_req_i,
  input  wire logic         dbe_req_i,
  output logic      [127:0] data_o,
  output logic              sbe_o,
  output logic              dbe_o
);
  logic [16:0]  line_q = '0;
  logic         ready  = 1'b0;
  logic [127:0] page;
  // four words, each stamped with line and word index
  assign page = {10'h2C3, line_q, 5'h03, 10'h2C3, line_q, 5'h02,
                 10'h2C3, line_q, 5'h01, 10'h2C3, line_q, 5'h00};
  // unsettled page shows the inverse, never the old line
  assign data_o = ready ? page : ~page;
  assign sbe_o  = ready & sbe_req_i;
  assign dbe_o  = ready & dbe_req_i;
  always_ff @(posedge clk_i) begin
    line_q <= rd_i ? line_i : line_q;
    ready  <= ~rd_i;
  end
endmodule : flash_array_model

// File: flash_read_accelerator_ctrl.sv
// flash read accelerator: avalon slave for array reads, registers and
// program/erase sequencing; assumes a synchronous 128-bit array port with
// fixed latency and ecc syndrome flags supplied by the array macro
//
// The register addresses and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`include "flash_accel_defines.svh"
module flash_read_accelerator_ctrl #(
  parameter int ADDR_W    = 21,
  parameter int MASTERS   = 4,
  parameter int BLOCKS    = 32
) (
  input  wire logic              ref_clk_i,
  input  wire logic              sys_rst_i,
  input  wire logic [ADDR_W-1:0] mem_address_i,
  input  wire logic              mem_read_i,
  input  wire logic              mem_write_i,
  input  wire logic [7:0]        mem_byteenable_i,
  input  wire logic [63:0]       mem_writedata_i,
  input  wire logic [1:0]        mem_master_i,
  input  wire logic              mem_ifetch_i,
  output logic [63:0]            mem_readdata_o,
  output logic                   mem_waitrequest_o,
  output logic                   mem_error_o,
  input  wire logic [5:0]        csr_address_i,
  input  wire logic              csr_read_i,
  input  wire logic              csr_write_i,
  input  wire logic [31:0]       csr_writedata_i,
  output logic [31:0]            csr_readdata_o,
  output logic                   csr_waitrequest_o,
  output logic                   nonvolatile_array_rd_o,
  output logic [ADDR_W-5:0]      nonvolatile_array_line_o,
  input  wire logic [127:0]      nonvolatile_array_data_i,
  input  wire logic              nonvolatile_array_sbe_i,
  input  wire logic              nonvolatile_array_dbe_i,
  output logic                   nonvolatile_array_pgm_o,
  output logic                   nonvolatile_array_ers_o,
  output logic                   nonvolatile_array_shadow_o,
  output logic [ADDR_W-4:0]      nonvolatile_array_pgm_dw_o,
  output logic [63:0]            nonvolatile_array_pgm_data_o,
  output logic [BLOCKS-1:0]      nonvolatile_array_ers_sel_o
);
  localparam int LW = ADDR_W - 4;
  if (MASTERS > 4 || BLOCKS > 32 || ADDR_W < 8 || ADDR_W > 32) begin : g_chk
    $error("unsupported parameter value");
  end

  flash_accel_pkg::rd_state_type state;
  flash_accel_pkg::rd_state_type next_state;
  flash_accel_pkg::op_state_type op;

  logic [31:0]       ctrl;
  logic [31:0]       prot;
  logic [31:0]       lock;
  logic [31:0]       pgm_addr;
  logic [63:0]       pgm_data;
  logic [31:0]       ers_sel;
  logic [15:0]       ecc_cnt;
  logic              dbe_flag;
  logic              prot_flag;
  logic [7:0]        op_cnt;
  logic [4:0]        dly_cnt;
  logic [1:0]        wait_cnt;
  logic [127:0]      line_buf [4];
  logic [LW-1:0]     line_tag [4];
  logic [3:0]        line_vld;
  logic [1:0]        victim;
  logic [127:0]      fix_reg;
  logic              pf_busy;
  logic [LW-1:0]     pf_line;
  logic [1:0]        pf_cnt;
  logic              pf_run;

  // single-cycle lookup across all four lines
  function automatic logic [2:0] find_line(input logic [LW-1:0] l);
    find_line = 3'h4;
    for (int i = 0; i < 4; i++)
      if (line_vld[i] && line_tag[i] == l) find_line = 3'(i);
  endfunction : find_line

  function automatic logic [63:0] half_sel(input logic [127:0] d,
                                           input logic          hi);
    half_sel = hi ? d[127:64] : d[63:0];
  endfunction : half_sel

  wire [LW-1:0] req_line  = mem_address_i[ADDR_W-1:4];
  wire [2:0]    hit_idx   = find_line(req_line);
  wire          bufe      = ctrl[`CTRL_BUFE_BIT];
  wire          hit       = bufe && !hit_idx[2];
  wire [1:0]    mi        = mem_master_i;
  wire          rd_ok     = prot[{mi, 1'b0}];
  wire          wr_ok     = prot[{mi, 1'b1}];
  wire          be_word   = mem_byteenable_i == 8'h0F ||
                            mem_byteenable_i == 8'hF0 ||
                            mem_byteenable_i == 8'hFF;
  wire          rd_bad    = mem_read_i && !rd_ok;
  wire          wr_bad    = mem_write_i && (!wr_ok || !be_word);
  wire          idle      = state == flash_accel_pkg::ST_IDLE;
  wire          fast_rd   = idle && mem_read_i && rd_ok && hit &&
                            ctrl[`CTRL_DLY_LSB +: `CTRL_DLY_W] == 5'h00;
  wire          pgm_lock  = lock[pgm_addr[21:17]] &&
                            !ctrl[`CTRL_SHADOW_BIT];
  wire          demand    = idle && mem_read_i && rd_ok && !fast_rd;
  wire          pf_issue  = pf_busy && idle && !mem_read_i;

  // hit answers in the request cycle itself when the delay field is zero
  assign mem_waitrequest_o = !(fast_rd || rd_bad || mem_write_i ||
                               state == flash_accel_pkg::ST_RESP);
  assign mem_error_o = rd_bad || wr_bad;
  assign csr_waitrequest_o = 1'b0;

  // array port pipelined one deep, prefetch slots into idle cycles
  assign nonvolatile_array_rd_o   = (state == flash_accel_pkg::ST_IDLE &&
                                     (demand ? (ctrl[6:2] == 5'h00)
                                             : pf_issue)) ||
                                    (state == flash_accel_pkg::ST_DELAY &&
                                     dly_cnt == 5'h01);
  assign nonvolatile_array_line_o = pf_issue ? pf_line : req_line;

  wire [127:0] hit_data = line_buf[hit_idx[1:0]];
  wire [63:0]  rd_data  = fast_rd ? half_sel(hit_data, mem_address_i[3])
                                  : half_sel(fix_reg, mem_address_i[3]);
  assign mem_readdata_o = rd_data;

  always_comb begin
    next_state = state;
    case (state)
      flash_accel_pkg::ST_IDLE: begin
        if (demand)
          next_state = (ctrl[6:2] != 5'h00) ? flash_accel_pkg::ST_DELAY
                                            : flash_accel_pkg::ST_ARRAY;
        else if (pf_issue)
          next_state = flash_accel_pkg::ST_ARRAY;
      end
      flash_accel_pkg::ST_DELAY:
        if (dly_cnt == 5'h01) next_state = flash_accel_pkg::ST_ARRAY;
      flash_accel_pkg::ST_ARRAY:
        if (wait_cnt == `ARRAY_WAIT - 2'h1)
          next_state = flash_accel_pkg::ST_REG;
      // a prefetch line has no bus answer
      flash_accel_pkg::ST_REG:
        next_state = pf_run ? flash_accel_pkg::ST_IDLE
                            : flash_accel_pkg::ST_RESP;
      flash_accel_pkg::ST_RESP: next_state = flash_accel_pkg::ST_IDLE;
      default:                  next_state = flash_accel_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      state    <= flash_accel_pkg::ST_IDLE;
      dly_cnt  <= 5'h00;
      wait_cnt <= 2'h1;
    end else begin
      state    <= next_state;
      dly_cnt  <= demand ? ctrl[6:2] : dly_cnt - 5'h01;
      // counts cycles since the array read strobe
      wait_cnt <= (state == flash_accel_pkg::ST_ARRAY) ?
                  wait_cnt + 2'h1 : 2'h1;
    end
  end

  // corrected data registered before reaching the bus
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      fix_reg  <= 128'h0;
      ecc_cnt  <= 16'h0000;
      dbe_flag <= 1'b0;
    end else begin
      if (state == flash_accel_pkg::ST_REG)
        fix_reg <= nonvolatile_array_data_i;
      if (state == flash_accel_pkg::ST_REG && nonvolatile_array_sbe_i)
        ecc_cnt <= ecc_cnt + 16'h0001;
      if (state == flash_accel_pkg::ST_REG && nonvolatile_array_dbe_i)
        dbe_flag <= 1'b1;
      else if (csr_write_i && csr_address_i == `REG_STATUS &&
               csr_writedata_i[1])
        dbe_flag <= 1'b0;
    end
  end

  // prefetch next lines after a fetch miss; data reads never prefetch
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      line_vld <= 4'h0;
      victim   <= 2'h0;
      pf_busy  <= 1'b0;
      pf_line  <= '0;
      pf_cnt   <= 2'h0;
      pf_run   <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        line_buf[i] <= 128'h0;
        line_tag[i] <= '0;
      end
    end else begin
      if (state == flash_accel_pkg::ST_REG && !pf_run && bufe) begin
        line_buf[victim] <= nonvolatile_array_data_i;
        line_tag[victim] <= req_line;
        line_vld[victim] <= !nonvolatile_array_dbe_i;
        victim           <= victim + 2'h1;
      end else if (state == flash_accel_pkg::ST_REG && pf_run) begin
        if (find_line(pf_line) == 3'h4) begin
          line_buf[victim] <= nonvolatile_array_data_i;
          line_tag[victim] <= pf_line;
          line_vld[victim] <= !nonvolatile_array_dbe_i;
          victim           <= victim + 2'h1;
        end
        pf_line <= pf_line + LW'(1);
        pf_cnt  <= pf_cnt - 2'h1;
        pf_busy <= pf_cnt != 2'h1;
      end
      // prefetch rides the demand path: one array read at a time
      if (pf_issue) pf_run <= 1'b1;
      else if (state == flash_accel_pkg::ST_REG) pf_run <= 1'b0;
      if (state == flash_accel_pkg::ST_RESP && mem_ifetch_i &&
          ctrl[`CTRL_PFE_BIT] && bufe) begin
        pf_busy <= 1'b1;
        pf_line <= req_line + LW'(1);
        pf_cnt  <= 2'h3;
      end
      if (op != flash_accel_pkg::OP_IDLE) line_vld <= 4'h0;
    end
  end

  // embedded program/erase sequencer; software only starts and suspends
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      op     <= flash_accel_pkg::OP_IDLE;
      op_cnt <= 8'h00;
    end else begin
      case (op)
        flash_accel_pkg::OP_IDLE: begin
          if (ctrl[`CTRL_PGM_BIT] && !pgm_lock && pgm_addr[2:0] == 3'h0) begin
            op     <= flash_accel_pkg::OP_PGM;
            op_cnt <= `PGM_CYCLES;
          end else if (ctrl[`CTRL_ERS_BIT]) begin
            op     <= flash_accel_pkg::OP_ERS;
            op_cnt <= `ERS_CYCLES;
          end
        end
        flash_accel_pkg::OP_PGM:
          if (op_cnt == 8'h01) op <= flash_accel_pkg::OP_IDLE;
          else op_cnt <= op_cnt - 8'h01;
        flash_accel_pkg::OP_ERS:
          if (ctrl[`CTRL_SUSP_BIT]) op <= flash_accel_pkg::OP_SUSP;
          else if (op_cnt == 8'h01) op <= flash_accel_pkg::OP_IDLE;
          else op_cnt <= op_cnt - 8'h01;
        flash_accel_pkg::OP_SUSP:
          if (!ctrl[`CTRL_SUSP_BIT]) op <= flash_accel_pkg::OP_ERS;
        default: op <= flash_accel_pkg::OP_IDLE;
      endcase
    end
  end

  wire op_start = op == flash_accel_pkg::OP_IDLE &&
                  (ctrl[`CTRL_PGM_BIT] || ctrl[`CTRL_ERS_BIT]);
  assign nonvolatile_array_pgm_o      = op == flash_accel_pkg::OP_PGM;
  assign nonvolatile_array_ers_o      = op == flash_accel_pkg::OP_ERS;
  assign nonvolatile_array_shadow_o   = ctrl[`CTRL_SHADOW_BIT];
  assign nonvolatile_array_pgm_dw_o   = pgm_addr[ADDR_W-1:3];
  assign nonvolatile_array_pgm_data_o = pgm_data;
  assign nonvolatile_array_ers_sel_o  = ctrl[`CTRL_SHADOW_BIT] ?
                                        '0 : ers_sel[BLOCKS-1:0] &
                                        ~lock[BLOCKS-1:0];

  wire csr_wr = csr_write_i;
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      ctrl     <= `CTRL_RESET;
      prot     <= `PROT_RESET;
      lock     <= `LOCK_RESET;
      pgm_addr <= 32'h0000_0000;
      pgm_data <= 64'h0;
      ers_sel  <= 32'h0000_0000;
      prot_flag <= 1'b0;
    end else begin
      if (csr_wr && csr_address_i == `REG_CTRL) ctrl <= csr_writedata_i;
      else if (op_start) begin
        ctrl[`CTRL_PGM_BIT] <= 1'b0;
        ctrl[`CTRL_ERS_BIT] <= 1'b0;
      end
      if (csr_wr && csr_address_i == `REG_PROT) prot <= csr_writedata_i;
      if (csr_wr && csr_address_i == `REG_LOCK) lock <= csr_writedata_i;
      if (csr_wr && csr_address_i == `REG_PGM_ADDR) pgm_addr <= csr_writedata_i;
      if (csr_wr && csr_address_i == `REG_PGM_LO) pgm_data[31:0] <= csr_writedata_i;
      if (csr_wr && csr_address_i == `REG_PGM_HI) pgm_data[63:32] <= csr_writedata_i;
      if (csr_wr && csr_address_i == `REG_ERASE_SEL) ers_sel <= csr_writedata_i;
      if (rd_bad || wr_bad) prot_flag <= 1'b1;
      else if (csr_wr && csr_address_i == `REG_STATUS && csr_writedata_i[2])
        prot_flag <= 1'b0;
    end
  end

  wire [31:0] status = {28'h0, op == flash_accel_pkg::OP_SUSP, prot_flag,
                        dbe_flag, op != flash_accel_pkg::OP_IDLE};
  always_comb begin
    case (csr_address_i)
      `REG_CTRL:      csr_readdata_o = ctrl;
      `REG_PROT:      csr_readdata_o = prot;
      `REG_LOCK:      csr_readdata_o = lock;
      `REG_PGM_ADDR:  csr_readdata_o = pgm_addr;
      `REG_PGM_LO:    csr_readdata_o = pgm_data[31:0];
      `REG_PGM_HI:    csr_readdata_o = pgm_data[63:32];
      `REG_STATUS:    csr_readdata_o = status;
      `REG_ECC_CNT:   csr_readdata_o = {16'h0000, ecc_cnt};
      `REG_ERASE_SEL: csr_readdata_o = ers_sel;
      default:        csr_readdata_o = 32'h0000_0000;
    endcase
  end

  property p_miss_latency;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (idle && mem_read_i && rd_ok && !fast_rd && ctrl[6:2] == 5'h00)
      |-> mem_waitrequest_o [*3] ##1 !mem_waitrequest_o;
  endproperty
  a_miss_latency: assert property (p_miss_latency)
    else $error("array read latency wrong");

  property p_hit_nowait;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    fast_rd |-> !mem_waitrequest_o;
  endproperty
  a_hit_nowait: assert property (p_hit_nowait)
    else $error("buffer hit stalled");

  property p_prot_err;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (mem_read_i && !rd_ok) |-> mem_error_o ##1 prot_flag;
  endproperty
  a_prot_err: assert property (p_prot_err)
    else $error("protection not enforced");

  property p_ecc_count;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (state == flash_accel_pkg::ST_REG && nonvolatile_array_sbe_i &&
     !(&ecc_cnt)) |=> ecc_cnt == $past(ecc_cnt) + 16'h0001;
  endproperty
  a_ecc_count: assert property (p_ecc_count)
    else $error("correction not counted");

  property p_pgm_len;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    $rose(nonvolatile_array_pgm_o) |-> nonvolatile_array_pgm_o [*8];
  endproperty
  a_pgm_len: assert property (p_pgm_len)
    else $error("program pulse too short");

  property p_suspend;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (op == flash_accel_pkg::OP_ERS && ctrl[`CTRL_SUSP_BIT])
      |=> !nonvolatile_array_ers_o;
  endproperty
  a_suspend: assert property (p_suspend)
    else $error("erase not suspended");

  property p_pf_ifetch;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    $rose(pf_busy) |-> $past(mem_ifetch_i);
  endproperty
  a_pf_ifetch: assert property (p_pf_ifetch)
    else $error("prefetch on data read");

  property p_write_size;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (mem_write_i && mem_byteenable_i == 8'h01) |-> mem_error_o;
  endproperty
  a_write_size: assert property (p_write_size)
    else $error("bad write size accepted");
endmodule : flash_read_accelerator_ctrl

// File: test_flash_read_accelerator_ctrl.sv
// self-checking bench for the flash read accelerator
// assumes the array model as far side; bus answers sampled at rising edges
`timescale 1ns/100ps
`include "flash_accel_defines.svh"
module test_flash_read_accelerator_ctrl;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic [20:0]  m_addr = '0;
  logic         m_rd = 1'b0, m_wr = 1'b0, m_fetch = 1'b0;
  logic [7:0]   m_be = '0;
  logic [1:0]   m_id = '0;
  logic [63:0]  m_rdata, rdat;
  logic         m_wait, m_err, er;
  logic [5:0]   c_addr = '0;
  logic         c_rd = 1'b0, c_wr = 1'b0, c_wait;
  logic [31:0]  c_wdata = '0, c_rdata, v;
  logic         a_rd, a_sbe, a_dbe, a_pgm, a_ers, a_shadow;
  logic         sbe_req = 1'b0, dbe_req = 1'b0;
  logic [16:0]  a_line;
  logic [127:0] a_data;
  logic [17:0]  a_dw;
  logic [63:0]  a_pdata;
  logic [31:0]  a_sel;
  int           fail_count = 0, checks_done = 0, nw, n;

  always #25 clk = ~clk;

  flash_read_accelerator_ctrl uut (
    .ref_clk_i(clk), .sys_rst_i(rst), .mem_address_i(m_addr),
    .mem_read_i(m_rd), .mem_write_i(m_wr), .mem_byteenable_i(m_be),
    .mem_writedata_i(64'hFEED_0000_1234_5678), .mem_master_i(m_id),
    .mem_ifetch_i(m_fetch), .mem_readdata_o(m_rdata),
    .mem_waitrequest_o(m_wait), .mem_error_o(m_err),
    .csr_address_i(c_addr), .csr_read_i(c_rd), .csr_write_i(c_wr),
    .csr_writedata_i(c_wdata), .csr_readdata_o(c_rdata),
    .csr_waitrequest_o(c_wait), .nonvolatile_array_rd_o(a_rd),
    .nonvolatile_array_line_o(a_line), .nonvolatile_array_data_i(a_data),
    .nonvolatile_array_sbe_i(a_sbe), .nonvolatile_array_dbe_i(a_dbe),
    .nonvolatile_array_pgm_o(a_pgm), .nonvolatile_array_ers_o(a_ers),
    .nonvolatile_array_shadow_o(a_shadow),
    .nonvolatile_array_pgm_dw_o(a_dw),
    .nonvolatile_array_pgm_data_o(a_pdata),
    .nonvolatile_array_ers_sel_o(a_sel));

  flash_array_model far_array (
    .clk_i(clk), .rd_i(a_rd), .line_i(a_line), .sbe_req_i(sbe_req),
    .dbe_req_i(dbe_req), .data_o(a_data), .sbe_o(a_sbe), .dbe_o(a_dbe));

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input string what, input logic [63:0] exp,
                       input logic [63:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  function automatic logic [63:0] exp_half(input logic [20:0] a);
    return {10'h2C3, a[20:4], 3'h0, a[3], 1'b1,
            10'h2C3, a[20:4], 3'h0, a[3], 1'b0};
  endfunction : exp_half

  // request held until waitrequest is sampled low at a rising edge
  task automatic mem_acc(input logic wr, input logic [20:0] a,
                         input logic f, input logic [1:0] id,
                         input logic [7:0] be);
    int i;
    @(posedge clk);
    m_addr  <= a;
    m_rd    <= ~wr;
    m_wr    <= wr;
    m_fetch <= f;
    m_id    <= id;
    m_be    <= be;
    for (i = 0; i < 100; i++) begin
      @(posedge clk);
      if (m_wait === 1'b0) break;
    end
    if (i == 100) begin
      check("mem waitrequest", 64'h0, 64'h1);
      give_verdict();
    end
    nw = i;
    rdat = m_rdata;
    er = m_err;
    m_rd <= 1'b0;
    m_wr <= 1'b0;
  endtask : mem_acc

  task automatic csr_acc(input logic wr, input logic [5:0] a,
                         input logic [31:0] wd);
    int i;
    @(posedge clk);
    c_addr  <= a;
    c_rd    <= ~wr;
    c_wr    <= wr;
    c_wdata <= wd;
    for (i = 0; i < 100; i++) begin
      @(posedge clk);
      if (c_wait === 1'b0) break;
    end
    if (i == 100) begin
      check("csr waitrequest", 64'h0, 64'h1);
      give_verdict();
    end
    v = c_rdata;
    c_rd <= 1'b0;
    c_wr <= 1'b0;
  endtask : csr_acc

  // cycles of program or erase strobe seen high in a fixed window
  task automatic count_high(input logic ers);
    n = 0;
    repeat (200) begin
      @(negedge clk);
      if ((ers ? a_ers : a_pgm) === 1'b1) n++;
    end
  endtask : count_high

  task automatic test_regs();
    csr_acc(1'b0, `REG_CTRL, '0);
    check("ctrl reset", 64'(`CTRL_RESET), 64'(v));
    csr_acc(1'b0, `REG_PROT, '0);
    check("prot reset", 64'(`PROT_RESET), 64'(v));
    csr_acc(1'b0, `REG_LOCK, '0);
    check("lock reset", 64'(`LOCK_RESET), 64'(v));
    csr_acc(1'b1, 6'h3C, 32'hFFFF_FFFF);
    csr_acc(1'b0, 6'h3C, '0);
    check("unmapped", 64'h0, 64'(v));
    $display("test_regs done");
  endtask : test_regs

  task automatic test_reads();
    logic [7:0] bes [4];
    bes = '{8'h01, 8'h03, 8'h0F, 8'hFF};
    mem_acc(1'b0, 21'h00_0100, 1'b0, 2'h0, 8'hFF);
    check("miss waits", 64'h3, 64'(nw));
    check("miss data", exp_half(21'h00_0100), rdat);
    for (int k = 0; k < 4; k++) begin
      mem_acc(1'b0, 21'h00_0108, 1'b0, 2'h3, bes[k]);
      check("size error", 64'h0, 64'(er));
      check("upper half", exp_half(21'h00_0108), rdat);
    end
    $display("test_reads done");
  endtask : test_reads

  task automatic test_prefetch();
    mem_acc(1'b0, 21'h00_1000, 1'b1, 2'h0, 8'hFF);
    check("fetch miss waits", 64'h3, 64'(nw));
    repeat (40) @(posedge clk);
    mem_acc(1'b0, 21'h00_1010, 1'b1, 2'h0, 8'hFF);
    check("next line waits", 64'h0, 64'(nw));
    check("next line data", exp_half(21'h00_1010), rdat);
    mem_acc(1'b0, 21'h00_1038, 1'b1, 2'h0, 8'hFF);
    check("third line waits", 64'h0, 64'(nw));
    check("third line data", exp_half(21'h00_1038), rdat);
    mem_acc(1'b0, 21'h00_2000, 1'b0, 2'h1, 8'hFF);
    repeat (40) @(posedge clk);
    mem_acc(1'b0, 21'h00_2010, 1'b0, 2'h1, 8'hFF);
    check("data no prefetch", 64'h3, 64'(nw));
    $display("test_prefetch done");
  endtask : test_prefetch

  task automatic test_delay();
    csr_acc(1'b1, `REG_CTRL, 32'h0000_007F);
    mem_acc(1'b0, 21'h00_3000, 1'b0, 2'h0, 8'hFF);
    check("delayed waits", 64'd34, 64'(nw));
    check("delayed data", exp_half(21'h00_3000), rdat);
    csr_acc(1'b1, `REG_CTRL, `CTRL_RESET);
    $display("test_delay done");
  endtask : test_delay

  task automatic test_protect();
    csr_acc(1'b1, `REG_PROT, 32'h0000_FFE7);
    mem_acc(1'b0, 21'h00_0100, 1'b0, 2'h2, 8'hFF);
    check("read refused", 64'h1, 64'(er));
    mem_acc(1'b1, 21'h00_0100, 1'b0, 2'h1, 8'h0F);
    check("write refused", 64'h1, 64'(er));
    mem_acc(1'b1, 21'h00_0100, 1'b0, 2'h0, 8'h01);
    check("byte write", 64'h1, 64'(er));
    mem_acc(1'b1, 21'h00_0100, 1'b0, 2'h0, 8'hF0);
    check("word write", 64'h0, 64'(er));
    csr_acc(1'b0, `REG_STATUS, '0);
    check("prot flag", 64'h1, 64'(v[2]));
    csr_acc(1'b1, `REG_STATUS, 32'h0000_0004);
    csr_acc(1'b0, `REG_STATUS, '0);
    check("prot flag clear", 64'h0, 64'(v[2]));
    csr_acc(1'b1, `REG_PROT, `PROT_RESET);
    $display("test_protect done");
  endtask : test_protect

  task automatic test_ecc();
    sbe_req <= 1'b1;
    mem_acc(1'b0, 21'h00_4000, 1'b0, 2'h0, 8'hFF);
    sbe_req <= 1'b0;
    check("corrected data", exp_half(21'h00_4000), rdat);
    csr_acc(1'b0, `REG_ECC_CNT, '0);
    check("ecc count", 64'h1, 64'(v));
    dbe_req <= 1'b1;
    mem_acc(1'b0, 21'h00_5000, 1'b0, 2'h0, 8'hFF);
    dbe_req <= 1'b0;
    csr_acc(1'b0, `REG_STATUS, '0);
    check("double flag", 64'h1, 64'(v[1]));
    $display("test_ecc done");
  endtask : test_ecc

  task automatic test_program();
    csr_acc(1'b1, `REG_PGM_ADDR, 32'h0000_0008);
    csr_acc(1'b1, `REG_PGM_LO, 32'hA1B2_C3D4);
    csr_acc(1'b1, `REG_PGM_HI, 32'h5E6F_7081);
    csr_acc(1'b1, `REG_CTRL, 32'h0000_0103);
    count_high(1'b0);
    check("locked program", 64'h0, 64'(n));
    csr_acc(1'b1, `REG_LOCK, 32'hFFFF_FFFE);
    csr_acc(1'b1, `REG_CTRL, 32'h0000_0103);
    count_high(1'b0);
    check("program length", 64'(`PGM_CYCLES), 64'(n));
    check("program dword", 64'h1, 64'(a_dw));
    check("program page", 64'h5E6F_7081_A1B2_C3D4, a_pdata);
    csr_acc(1'b1, `REG_PGM_ADDR, 32'h0000_000C);
    csr_acc(1'b1, `REG_CTRL, 32'h0000_0103);
    count_high(1'b0);
    check("misaligned program", 64'h0, 64'(n));
    $display("test_program done");
  endtask : test_program

  task automatic test_erase();
    csr_acc(1'b1, `REG_LOCK, `LOCK_RESET);
    csr_acc(1'b1, `REG_PGM_ADDR, 32'h0000_0008);
    csr_acc(1'b1, `REG_CTRL, 32'h0000_0183);
    @(negedge clk);
    check("shadow select", 64'h1, 64'(a_shadow));
    count_high(1'b0);
    check("shadow program", 64'(`PGM_CYCLES), 64'(n));
    csr_acc(1'b1, `REG_ERASE_SEL, 32'h0000_0005);
    csr_acc(1'b1, `REG_CTRL, 32'h0000_0283);
    @(negedge clk);
    check("shadow erase sel", 64'h0, 64'(a_sel));
    count_high(1'b1);
    check("erase length", 64'(`ERS_CYCLES), 64'(n));
    csr_acc(1'b1, `REG_LOCK, 32'hFFFF_FFFE);
    csr_acc(1'b1, `REG_CTRL, 32'h0000_0203);
    @(negedge clk);
    check("erase sel", 64'h1, 64'(a_sel));
    csr_acc(1'b1, `REG_CTRL, 32'h0000_0403);
    csr_acc(1'b0, `REG_STATUS, '0);
    check("suspended", 64'h1, 64'(v[3]));
    $display("test_erase done");
  endtask : test_erase

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    test_regs();
    test_reads();
    test_prefetch();
    test_delay();
    test_protect();
    test_ecc();
    test_program();
    test_erase();
    give_verdict();
  end
endmodule : test_flash_read_accelerator_ctrl
